// file: rtl/tlbx_top.sv
// instruction and data translation buffers with software reload ports
// assumes the core holds lookup inputs steady and reads the registered results one cycle later
`timescale 1ns/1ns
module tlbx_top
    import tlbx_pkg::*;
#(
    parameter int ENTRIES = TLBX_ENTRIES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // machine state bits
    input wire logic problem_state_bit_i,
    input wire logic instr_relocate_bit_i,
    input wire logic data_relocate_bit_i,
    // instruction lookup
    input wire logic [31:0] instr_side_prefix_ea_i,
    output logic [31:0] instr_side_prefix_ra_o,
    output logic instr_side_prefix_hit_o,
    output logic instr_side_prefix_miss_o,
    output logic [1:0] instr_side_prefix_access_o,
    // data lookup
    input wire logic [31:0] data_side_prefix_ea_i,
    output logic [31:0] data_side_prefix_ra_o,
    output logic data_side_prefix_hit_o,
    output logic data_side_prefix_miss_o,
    output logic [1:0] data_side_prefix_access_o,
    // special register write port
    input wire logic spr_wr_i,
    input wire logic spr_data_side_i,
    input wire logic [2:0] spr_idx_i,
    input wire logic [21:0] spr_epn_i,
    input wire logic [21:0] spr_rpn_i,
    input wire logic [1:0] spr_size_i,
    input wire logic [3:0] spr_sub_i,
    input wire logic [3:0] spr_entry_space_id_i,
    input wire logic spr_shared_i,
    input wire logic [1:0] spr_priv_i,
    input wire logic [3:0] spr_apg_i,
    input wire logic current_space_id_wr_i,
    input wire logic [3:0] current_space_id_i,
    input wire logic apr_wr_i,
    input wire logic [31:0] apr_i,
    input wire logic scratch_wr_i,
    input wire logic [31:0] scratch_i,
    // maintenance
    input wire logic [3:0] cmd_i,
    input wire logic [31:0] cmd_ea_i,
    // special register read port
    input wire logic spr_rd_side_i,
    input wire logic [2:0] spr_rd_idx_i,
    output logic spr_rd_valid_o,
    output logic [21:0] spr_rd_epn_o,
    output logic [21:0] spr_rd_rpn_o,
    output logic [3:0] spr_rd_sub_o,
    output logic [3:0] current_space_id_o,
    output logic [31:0] scratch_o
);
    // ****************************************
    // entry storage, index 0 instruction, 1 data
    // ****************************************
    logic entry_valid [2][ENTRIES];  // entry live
    logic [21:0] effective_page_number [2][ENTRIES];
    logic [21:0] real_page [2][ENTRIES];
    logic [1:0] page_size [2][ENTRIES];
    logic [3:0] sub_valid [2][ENTRIES];
    logic [3:0] entry_space_id [2][ENTRIES];
    logic shared_flag [2][ENTRIES];
    logic [1:0] priv_mode [2][ENTRIES];
    logic [3:0] protection_group [2][ENTRIES];
    logic [3:0] current_space_id_reg;  // current space
    logic [31:0] access_prot;  // sixteen 2-bit fields
    logic [31:0] scratch;  // refill routine scratch

    // ****************************************
    // helper: compare mask for page size
    // ****************************************
    // mask over the 22 stored page bits (ea[31:10]); bits below the page kept untranslated
    function automatic logic [21:0] size_mask(input logic [1:0] ps);
        logic [21:0] m;
        m = 22'h3f_ffff;
        case (ps)
            TLBX_PS_4K: m = 22'h3f_fffc;
            TLBX_PS_16K: m = 22'h3f_fff0;
            TLBX_PS_512K: m = 22'h3f_fe00;
            TLBX_PS_8M: m = 22'h3f_e000;
            default: m = 22'h3f_fffc;
        endcase
        return m;
    endfunction

    // privilege check for one entry
    function automatic logic priv_ok(input logic [1:0] mode, input logic pr);
        logic ok;
        case (mode)
            TLBX_PRV_USER: ok = pr;
            TLBX_PRV_SUPV: ok = ~pr;
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    // ****************************************
    // lookup, both sides
    // ****************************************
    wire logic [31:0] ea_sel [2];
    wire logic xlate_on [2];
    assign ea_sel[0] = instr_side_prefix_ea_i;
    assign ea_sel[1] = data_side_prefix_ea_i;
    assign xlate_on[0] = instr_relocate_bit_i;
    assign xlate_on[1] = data_relocate_bit_i;

    logic [31:0] ra_c [2];
    logic hit_c [2];
    logic [1:0] acc_c [2];

    always_comb begin
        for (int s = 0; s < 2; s++) begin
            logic [21:0] msk;
            logic [21:0] pg;
            logic m;
            msk = 22'h00_0000;
            pg = 22'h00_0000;
            m = 1'b0;
            hit_c[s] = 1'b0;
            ra_c[s] = ea_sel[s];
            acc_c[s] = 2'h0;
            for (int e = 0; e < ENTRIES; e++) begin
                msk = size_mask(page_size[s][e]);
                m = entry_valid[s][e]
                    && (((ea_sel[s][31:10] ^ effective_page_number[s][e]) & msk) == 22'h00_0000)
                    && (shared_flag[s][e] || entry_space_id[s][e] == current_space_id_reg)
                    && sub_valid[s][e][ea_sel[s][11:10]]
                    && priv_ok(priv_mode[s][e], problem_state_bit_i);
                if (m && xlate_on[s] && !hit_c[s]) begin
                    hit_c[s] = 1'b1;
                    // join real page with low bits
                    ra_c[s] = {(real_page[s][e] & msk) | (ea_sel[s][31:10] & ~msk), ea_sel[s][9:0]};
                    acc_c[s] = access_prot[{protection_group[s][e], 1'b0} +: 2];
                end
            end
            if (!xlate_on[s]) begin
                ra_c[s] = ea_sel[s];
            end
        end
    end

    // ****************************************
    // registered lookup results
    // ****************************************
    // one cycle latency keeps the 8-way compare off the cache path
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            instr_side_prefix_ra_o <= 32'h0000_0000;
            data_side_prefix_ra_o <= 32'h0000_0000;
            instr_side_prefix_hit_o <= 1'b0;
            data_side_prefix_hit_o <= 1'b0;
            instr_side_prefix_miss_o <= 1'b0;
            data_side_prefix_miss_o <= 1'b0;
            instr_side_prefix_access_o <= 2'h0;
            data_side_prefix_access_o <= 2'h0;
        end else begin
            instr_side_prefix_ra_o <= ra_c[0];
            data_side_prefix_ra_o <= ra_c[1];
            instr_side_prefix_hit_o <= hit_c[0];
            data_side_prefix_hit_o <= hit_c[1];
            instr_side_prefix_miss_o <= xlate_on[0] && !hit_c[0];
            data_side_prefix_miss_o <= xlate_on[1] && !hit_c[1];
            instr_side_prefix_access_o <= acc_c[0];
            data_side_prefix_access_o <= acc_c[1];
        end
    end

    // ****************************************
    // overlap detection for reload
    // ****************************************
    wire logic ws = spr_data_side_i;
    wire logic [21:0] new_msk = size_mask(spr_size_i);
    logic [ENTRIES-1:0] overlap;
    logic [ENTRIES-1:0] inv_hit [2];  // invalidate-one page match per side

    // overlap by size, sub, priv, space, shared
    always_comb begin
        for (int e = 0; e < ENTRIES; e++) begin
            logic [21:0] jm;
            jm = new_msk & size_mask(page_size[ws][e]);
            overlap[e] = entry_valid[ws][e] && (e != int'(spr_idx_i))
                && (((spr_epn_i ^ effective_page_number[ws][e]) & jm) == 22'h00_0000)
                && ((spr_sub_i & sub_valid[ws][e]) != 4'h0)
                && !((spr_priv_i == TLBX_PRV_USER && priv_mode[ws][e] == TLBX_PRV_SUPV)
                     || (spr_priv_i == TLBX_PRV_SUPV && priv_mode[ws][e] == TLBX_PRV_USER))
                && (spr_shared_i || shared_flag[ws][e] || spr_entry_space_id_i == entry_space_id[ws][e]);
            // single invalidate hits either side on page match
            for (int s = 0; s < 2; s++) begin
                inv_hit[s][e] = (((cmd_ea_i[31:10] ^ effective_page_number[s][e])
                                  & size_mask(page_size[s][e])) == 22'h00_0000);
            end
        end
    end

    // ****************************************
    // entry update process
    // ****************************************
    // sync (and any unknown code) falls through and does nothing
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            for (int s = 0; s < 2; s++) begin
                for (int e = 0; e < ENTRIES; e++) begin
                    entry_valid[s][e] <= 1'b0;
                    effective_page_number[s][e] <= 22'h00_0000;
                    real_page[s][e] <= 22'h00_0000;
                    page_size[s][e] <= TLBX_PS_4K;
                    sub_valid[s][e] <= 4'h0;
                    entry_space_id[s][e] <= 4'h0;
                    shared_flag[s][e] <= 1'b0;
                    priv_mode[s][e] <= TLBX_PRV_BOTH;
                    protection_group[s][e] <= 4'h0;
                end
            end
        end else begin
            if (cmd_i == TLBX_CMD_INV_ALL) begin
                for (int s = 0; s < 2; s++) begin
                    for (int e = 0; e < ENTRIES; e++) begin
                        entry_valid[s][e] <= 1'b0;
                    end
                end
            end else if (cmd_i == TLBX_CMD_INV_ONE) begin
                for (int s = 0; s < 2; s++) begin
                    for (int e = 0; e < ENTRIES; e++) begin
                        if (inv_hit[s][e]) begin
                            entry_valid[s][e] <= 1'b0;
                        end
                    end
                end
            end
            if (spr_wr_i) begin
                for (int e = 0; e < ENTRIES; e++) begin
                    if (overlap[e]) begin
                        entry_valid[ws][e] <= 1'b0;
                    end
                end
                entry_valid[ws][spr_idx_i] <= 1'b1;
                effective_page_number[ws][spr_idx_i] <= spr_epn_i;
                real_page[ws][spr_idx_i] <= spr_rpn_i;
                page_size[ws][spr_idx_i] <= spr_size_i;
                sub_valid[ws][spr_idx_i] <= spr_sub_i;
                entry_space_id[ws][spr_idx_i] <= spr_entry_space_id_i;
                shared_flag[ws][spr_idx_i] <= spr_shared_i;
                priv_mode[ws][spr_idx_i] <= spr_priv_i;
                protection_group[ws][spr_idx_i] <= spr_apg_i;
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            current_space_id_reg <= 4'h0;
            access_prot <= TLBX_APR_RST;
            scratch <= TLBX_SCRATCH_RST;
        end else begin
            if (current_space_id_wr_i) begin
                current_space_id_reg <= current_space_id_i;
            end
            if (apr_wr_i) begin
                access_prot <= apr_i;
            end
            if (scratch_wr_i) begin
                scratch <= scratch_i;
            end
        end
    end

    // ****************************************
    // read-back
    // ****************************************
    // entry readback
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            spr_rd_valid_o <= 1'b0;
            spr_rd_epn_o <= 22'h00_0000;
            spr_rd_rpn_o <= 22'h00_0000;
            spr_rd_sub_o <= 4'h0;
        end else begin
            spr_rd_valid_o <= entry_valid[spr_rd_side_i][spr_rd_idx_i];
            spr_rd_epn_o <= effective_page_number[spr_rd_side_i][spr_rd_idx_i];
            spr_rd_rpn_o <= real_page[spr_rd_side_i][spr_rd_idx_i];
            spr_rd_sub_o <= sub_valid[spr_rd_side_i][spr_rd_idx_i];
        end
    end
    assign current_space_id_o = current_space_id_reg;
    assign scratch_o = scratch;
endmodule // tlbx_top

// file: include/tlbx_pkg.sv
// package for the two-sided translation buffer block
// assumes a single 250 MHz clock domain shared with the core
package tlbx_pkg;
    // ****************************************
    // sizes and widths
    // ****************************************
    localparam int TLBX_ENTRIES = 8;      // entries per side
    localparam int TLBX_IDX_W = 3;        // entry index width
    localparam int TLBX_ADDR_W = 32;      // effective and real address width
    localparam int TLBX_EPN_W = 22;       // page number bits stored (1K granularity)
    localparam int TLBX_ENTRY_SPACE_ID_W = 4;       // sixteen address spaces
    localparam int TLBX_APG_W = 4;        // sixteen protection groups
    localparam int TLBX_APR_W = 32;       // 16 fields of 2 bits
    localparam int TLBX_APF_W = 2;        // width of one protection field
    localparam int TLBX_SUB_W = 4;        // four 1K subpage flags
    // ****************************************
    // page size encodings
    // ****************************************
    localparam logic [1:0] TLBX_PS_4K = 2'h0;
    localparam logic [1:0] TLBX_PS_16K = 2'h1;
    localparam logic [1:0] TLBX_PS_512K = 2'h2;
    localparam logic [1:0] TLBX_PS_8M = 2'h3;
    // low bit count passed through per page size
    localparam int TLBX_OFS_4K = 12;
    localparam int TLBX_OFS_16K = 14;
    localparam int TLBX_OFS_512K = 19;
    localparam int TLBX_OFS_8M = 23;
    // subpage index position inside a 4K page
    localparam int TLBX_SUB_LSB = 10;
    // ****************************************
    // privilege match modes
    // ****************************************
    localparam logic [1:0] TLBX_PRV_BOTH = 2'h0;
    localparam logic [1:0] TLBX_PRV_USER = 2'h1;
    localparam logic [1:0] TLBX_PRV_SUPV = 2'h2;
    // ****************************************
    // maintenance commands
    // ****************************************
    typedef enum logic [3:0] {
        TLBX_CMD_NONE = 4'b0001,
        TLBX_CMD_INV_ONE = 4'b0010,
        TLBX_CMD_INV_ALL = 4'b0100,
        TLBX_CMD_SYNC = 4'b1000
    } tlbx_cmd_e;
    localparam logic [31:0] TLBX_SCRATCH_RST = 32'h0000_0000;
    localparam logic [31:0] TLBX_APR_RST = 32'h0000_0000;
endpackage

// file: test/tlbx_monitor.sv
// checker for the translation buffer ports
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/1ns
module tlbx_monitor
    import tlbx_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic instr_relocate_bit_i,
    input wire logic data_relocate_bit_i,
    input wire logic [31:0] instr_side_prefix_ea_i,
    input wire logic [31:0] instr_side_prefix_ra_o,
    input wire logic instr_side_prefix_hit_o,
    input wire logic instr_side_prefix_miss_o,
    input wire logic data_side_prefix_hit_o,
    input wire logic data_side_prefix_miss_o,
    input wire logic spr_wr_i,
    input wire logic spr_data_side_i,
    input wire logic [2:0] spr_idx_i,
    input wire logic [21:0] spr_epn_i,
    input wire logic spr_rd_side_i,
    input wire logic [2:0] spr_rd_idx_i,
    input wire logic spr_rd_valid_o,
    input wire logic [21:0] spr_rd_epn_o,
    input wire logic current_space_id_wr_i,
    input wire logic [3:0] current_space_id_i,
    input wire logic [3:0] current_space_id_o,
    input wire logic scratch_wr_i,
    input wire logic [31:0] scratch_i,
    input wire logic [31:0] scratch_o,
    input wire logic [3:0] cmd_i
);
    // ****
    // sequences
    // ****
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // read of the entry just written, nothing else touching it
    sequence s_read_same;
        !spr_wr_i && cmd_i == TLBX_CMD_NONE && spr_rd_side_i == $past(spr_data_side_i)
            && spr_rd_idx_i == $past(spr_idx_i);
    endsequence
    sequence s_clear_all;
        cmd_i == TLBX_CMD_INV_ALL && !spr_wr_i ##1 !spr_wr_i;
    endsequence
    // ****
    // properties
    // ****
    property p_pass_i;
        !instr_relocate_bit_i |=> instr_side_prefix_ra_o == $past(instr_side_prefix_ea_i);
    endproperty
    a_pass_i: assert property (p_pass_i) else $error("instr address not passed through");
    property p_one_i;
        instr_relocate_bit_i |=> instr_side_prefix_hit_o ^ instr_side_prefix_miss_o;
    endproperty
    a_one_i: assert property (p_one_i) else $error("instr hit and miss disagree");
    property p_one_d;
        data_relocate_bit_i |=> data_side_prefix_hit_o ^ data_side_prefix_miss_o;
    endproperty
    a_one_d: assert property (p_one_d) else $error("data hit and miss disagree");
    property p_off_d;
        !data_relocate_bit_i |=> !data_side_prefix_miss_o;
    endproperty
    a_off_d: assert property (p_off_d) else $error("data miss with translation off");
    property p_low_i;
        instr_side_prefix_hit_o |-> instr_side_prefix_ra_o[11:0] == $past(instr_side_prefix_ea_i[11:0]);
    endproperty
    a_low_i: assert property (p_low_i) else $error("instr offset bits altered");
    property p_current_space_id;
        current_space_id_wr_i |=> current_space_id_o == $past(current_space_id_i);
    endproperty
    a_current_space_id: assert property (p_current_space_id) else $error("space id not stored");
    property p_scratch;
        scratch_wr_i |=> scratch_o == $past(scratch_i);
    endproperty
    a_scratch: assert property (p_scratch) else $error("scratch not stored");
    property p_readback;
        spr_wr_i ##1 s_read_same |=> spr_rd_valid_o && spr_rd_epn_o == $past(spr_epn_i, 2);
    endproperty
    a_readback: assert property (p_readback) else $error("written entry not read back");
    property p_inv_all;
        s_clear_all |=> !spr_rd_valid_o;
    endproperty
    a_inv_all: assert property (p_inv_all) else $error("entry survived clear");
endmodule // tlbx_monitor
bind tlbx_top tlbx_monitor mon_u (.*);

// file: test/tlbx_core_model.sv
// core-side model: fetch and load/store address drivers
// assumes the bench picks side and address between falling edges
`timescale 1ns/1ns
module tlbx_core_model (
    input wire logic clk_sys_i,
    input wire logic req_side_i,
    input wire logic [31:0] req_ea_i,
    output logic [31:0] instr_ea_o,
    output logic [31:0] data_ea_o
);
    logic [31:0] idle_ea = 32'h0000_0001; // churn on the unchecked side
    // the side not under test keeps looking up, so the buffers
    // must keep their answers apart
    always @(negedge clk_sys_i) begin
        idle_ea <= {idle_ea[30:0], idle_ea[31] ^ idle_ea[21] ^ idle_ea[1]};
    end
    assign instr_ea_o = req_side_i ? idle_ea : req_ea_i;
    assign data_ea_o = req_side_i ? req_ea_i : ~idle_ea;
endmodule // tlbx_core_model

// file: test/test_tlb_address_translation.sv
// self-checking bench for the two-sided translation buffers
// assumes the core model drives both lookup addresses
`timescale 1ns/1ns
module test_tlb_address_translation;
    import tlbx_pkg::*;
    // ****
    // signals
    // ****
    logic clk_sys_i = 0, rst_i = 1, problem_state_bit_i = 0, req_side = 0;
    logic instr_relocate_bit_i = 0, data_relocate_bit_i = 0, spr_rd_valid_o;
    logic spr_wr_i = 0, spr_data_side_i = 0, spr_shared_i = 0, spr_rd_side_i = 0;
    logic current_space_id_wr_i = 0, apr_wr_i = 0, scratch_wr_i = 0;
    logic [2:0] spr_idx_i = 0, spr_rd_idx_i = 0;
    logic [21:0] spr_epn_i = 0, spr_rpn_i = 0, spr_rd_epn_o, spr_rd_rpn_o;
    logic [1:0] spr_size_i = 0, spr_priv_i = 0, instr_side_prefix_access_o, data_side_prefix_access_o;
    logic [3:0] spr_sub_i = 0, spr_entry_space_id_i = 0, spr_apg_i = 0, current_space_id_i = 0, cmd_i = 4'h1;
    logic [3:0] spr_rd_sub_o, current_space_id_o;
    logic [31:0] apr_i = 0, scratch_i = 0, cmd_ea_i = 0, req_ea = 0, scratch_o, ea, base;
    logic [31:0] instr_side_prefix_ea_i, data_side_prefix_ea_i, instr_side_prefix_ra_o, data_side_prefix_ra_o;
    logic instr_side_prefix_hit_o, instr_side_prefix_miss_o, data_side_prefix_hit_o, data_side_prefix_miss_o;
    int mismatches = 0, n_checks = 0;
    integer seed = 32'hf57f_9f5e;
    always #2 clk_sys_i = ~clk_sys_i;
    tlbx_top dut_u (.*);
    tlbx_core_model core_u (.clk_sys_i(clk_sys_i), .req_side_i(req_side), .req_ea_i(req_ea),
        .instr_ea_o(instr_side_prefix_ea_i), .data_ea_o(data_side_prefix_ea_i));
    // ****
    // expectations and drivers
    // ****
    function automatic int ofs(input logic [1:0] z);
        return z == TLBX_PS_4K ? TLBX_OFS_4K : z == TLBX_PS_16K ? TLBX_OFS_16K
            : z == TLBX_PS_512K ? TLBX_OFS_512K : TLBX_OFS_8M;
    endfunction
    // real page above the offset, address below it
    function automatic logic [31:0] xra(input logic [31:0] e, input logic [21:0] r, input logic [1:0] z);
        logic [31:0] m;
        m = (32'h1 << ofs(z)) - 32'h1;
        return ({r, 10'h0} & ~m) | (e & m);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // entry write; read select follows it so readback can be watched
    task automatic wr(input logic s, input logic [2:0] i, input logic [21:0] e, input logic [21:0] r,
        input logic [1:0] z, input logic [3:0] sb, input logic [3:0] a, input logic sh, input logic [1:0] pv);
        @(negedge clk_sys_i);
        {spr_wr_i, spr_data_side_i, spr_idx_i, spr_epn_i, spr_rpn_i} = {1'b1, s, i, e, r};
        {spr_size_i, spr_sub_i, spr_entry_space_id_i, spr_shared_i, spr_priv_i} = {z, sb, a, sh, pv};
        spr_apg_i = {1'b0, i};
        {spr_rd_side_i, spr_rd_idx_i} = {s, i};
        @(negedge clk_sys_i);
        spr_wr_i = 0;
    endtask
    // one lookup; result is registered, so look one cycle on
    task automatic look(input logic s, input logic [31:0] e, input logic m, input logic [31:0] r);
        @(negedge clk_sys_i);
        req_side = s;
        req_ea = e;
        @(negedge clk_sys_i);
        chk({30'h0, s ? {data_side_prefix_hit_o, data_side_prefix_miss_o} : {instr_side_prefix_hit_o, instr_side_prefix_miss_o}},
            {30'h0, !m && (s ? data_relocate_bit_i : instr_relocate_bit_i), m});
        if (!m) chk(s ? data_side_prefix_ra_o : instr_side_prefix_ra_o, r);
    endtask
    task automatic rd(input logic s, input logic [2:0] i);
        @(negedge clk_sys_i);
        {spr_rd_side_i, spr_rd_idx_i} = {s, i};
        @(negedge clk_sys_i);
    endtask
    task automatic op(input logic [3:0] c, input logic [31:0] e);
        @(negedge clk_sys_i);
        cmd_i = c;
        cmd_ea_i = e;
        @(negedge clk_sys_i);
        cmd_i = TLBX_CMD_NONE;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    initial begin
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 0;
        chk(scratch_o, 0);
        for (int k = 0; k < 8; k++) begin
            ea = $random(seed);
            look(k[0], ea, 1'b0, ea);
        end
        $display("pass-through test done");
        @(negedge clk_sys_i);
        {current_space_id_wr_i, apr_wr_i, scratch_wr_i} = 3'h7;
        current_space_id_i = 4'h5;
        apr_i = $random(seed);
        scratch_i = $random(seed);
        @(negedge clk_sys_i);
        {current_space_id_wr_i, apr_wr_i, scratch_wr_i} = 3'h0;
        chk({28'h0, current_space_id_o}, 32'h0000_0005);
        chk(scratch_o, scratch_i);
        instr_relocate_bit_i = 1;
        data_relocate_bit_i = 1;
        // every page size, sides alternating, top bits keep pages apart
        for (int z = 0; z < 4; z++) begin
            ea = {z[1:0], 30'($random(seed))};
            base = ea & ~((32'h1 << ofs(z[1:0])) - 32'h1);
            wr(z[0], z[2:0], base[31:10], 22'($random(seed)), z[1:0], 4'hf, 4'h5, 1'b0, TLBX_PRV_BOTH);
            look(z[0], ea, 1'b0, xra(ea, spr_rpn_i, z[1:0]));
            chk({30'h0, z[0] ? data_side_prefix_access_o : instr_side_prefix_access_o}, 32'(apr_i[2 * z +: 2]));
            look(!z[0], ea, 1'b1, 0);
            look(z[0], ea ^ (32'h1 << ofs(z[1:0])), 1'b1, 0);
        end
        $display("page size test done");
        base = {2'h3, 30'($random(seed))} & 32'hffff_f000;
        wr(1'b0, 3'h4, base[31:10], spr_rpn_i, TLBX_PS_4K, 4'h5, 4'h5, 1'b0, TLBX_PRV_BOTH);
        for (int q = 0; q < 4; q++) begin
            ea = base | (32'(q) << 10) | 32'h0000_0123;
            look(1'b0, ea, !spr_sub_i[q], xra(ea, spr_rpn_i, TLBX_PS_4K));
        end
        base = {2'h2, 30'($random(seed))} & 32'hffff_f000;
        for (int h = 0; h < 3; h++) begin
            wr(1'b1, 3'h5, base[31:10], spr_rpn_i, TLBX_PS_4K, 4'hf, h == 2 ? 4'h5 : 4'h9, h == 1, TLBX_PRV_BOTH);
            look(1'b1, base, h == 0, xra(base, spr_rpn_i, TLBX_PS_4K));
        end
        for (int p = 0; p < 6; p++) begin
            problem_state_bit_i = p[0];
            wr(1'b1, 3'h5, base[31:10], spr_rpn_i, TLBX_PS_4K, 4'hf, 4'h5, 1'b0, 2'(p >> 1));
            look(1'b1, base, (p >> 1 == 1 && !p[0]) || (p >> 1 == 2 && p[0]), xra(base, spr_rpn_i, TLBX_PS_4K));
        end
        problem_state_bit_i = 0;
        $display("match condition test done");
        wr(1'b1, 3'h6, base[31:10], spr_rpn_i, TLBX_PS_4K, 4'hf, 4'h5, 1'b0, TLBX_PRV_BOTH);
        rd(1'b1, 3'h5);
        chk({31'h0, spr_rd_valid_o}, 0);
        rd(1'b1, 3'h6);
        chk({spr_rd_valid_o, 9'h0, spr_rd_epn_o}, {1'b1, 9'h0, base[31:10]});
        chk({spr_rd_sub_o, 6'h0, spr_rd_rpn_o}, {4'hf, 6'h0, spr_rpn_i});
        op(TLBX_CMD_SYNC, base);
        look(1'b1, base, 1'b0, xra(base, spr_rpn_i, TLBX_PS_4K));
        op(TLBX_CMD_INV_ONE, base);
        look(1'b1, base, 1'b1, 0);
        rd(1'b0, 3'h4);
        chk({31'h0, spr_rd_valid_o}, 1);
        op(TLBX_CMD_INV_ALL, 0);
        rd(1'b0, 3'h4);
        chk({31'h0, spr_rd_valid_o}, 0);
        $display("reload and maintenance test done");
        conclude();
    end
    // hang guard, far beyond the hundred-odd cycles needed
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        conclude();
    end
endmodule // test_tlb_address_translation
